/* hdl/dsc_mem.sv */
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// (R1) chip select high ignores new commands
// (R2) nop acts like deselect
// (R3) decode ras cas we into commands
// (R4) cke chooses auto or self refresh
// (R5) bank code selects mode or extended
// (R6) mode load only when banks idle
// (R7) activate opens row until precharge
// (R8) bank and column select burst start
// (R9) a10 sets auto precharge per command
// (R10) auto precharge closes row after burst
// (R11) mask high blocks that byte write
// (R12) a10 high precharges all banks
// (R13) precharged bank idle after precharge time
// (R14) precharge to idle bank is nop
// (R15) other bank access allowed during autoprecharge
// (R16) auto precharge waits for row active time
// (R17) no bank command before precharge done
// (R18) burst terminate cuts last plain read
// (R19) refresh uses internal counter, banks idle
// (R20) refresh average spacing within interval
// (R21) at most eight refreshes postponed; the controller's owed count can reach nine
// (R22) cke high through refresh period
// (R23) inputs sampled on rising clock edge
module dsc_mem #(
	parameter int ROW_W = dsc_pkg::ROW_W,
	parameter int REF_W = 13
) (
	input wire logic clock,
	input wire logic sys_rst,
	dsc_if.mem bus,
	output logic [3:0] bank_open_ff,
	output logic [3:0] bank_pre_ff,
	output logic [ROW_W-1:0] last_row_ff,
	output logic [13:0] mode_reg_ff,
	output logic [13:0] emode_reg_ff,
	output logic self_ref_ff,
	output logic [REF_W-1:0] ref_row_ff,
	output logic rd_active_ff,
	output logic wr_active_ff,
	output logic [1:0] burst_bank_ff,
	output logic [12:0] burst_col_ff,
	output logic [1:0] wr_mask_ff,
	output logic [15:0] wr_data_ff,
	output logic wr_strobe_ff,
	output logic err_ff
);
	dsc_pkg::dsc_cmd_e cmd;
	logic [3:0] ras_cnt_ff [4];
	logic [3:0] rp_cnt_ff [4];
	logic [3:0] ap_pend_ff;
	logic burst_ap_ff;
	logic [3:0] burst_cnt_ff;
	logic [ROW_W-1:0] row_ff [4];
	logic [3:0] busy_cnt_ff;
	logic all_idle;
	logic burst_done;
	logic ref_ok;

	// all inputs arrive registered on the rising edge
	dsc_cmd_decode u_dec ( // R23
		.cs_n(bus.cs_n),
		.ras_n(bus.ras_n),
		.cas_n(bus.cas_n),
		.we_n(bus.we_n),
		.cmd(cmd)
	);

	assign all_idle = (bank_open_ff == 4'h0) && (bank_pre_ff == 4'h0);
	assign burst_done = (rd_active_ff || wr_active_ff) && (burst_cnt_ff == 4'h1);
	assign ref_ok = bus.cke && cmd == dsc_pkg::DSC_CMD_REF && all_idle && !self_ref_ff;

	// bank state: open, precharging, counters
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bank_open_ff <= 4'h0;
			bank_pre_ff <= 4'h0;
			ap_pend_ff <= 4'h0;
			last_row_ff <= '0;
			for (int i = 0; i < 4; i++) begin
				ras_cnt_ff[i] <= 4'h0;
				rp_cnt_ff[i] <= 4'h0;
				row_ff[i] <= '0;
			end
		end else if (!self_ref_ff) begin
			for (int i = 0; i < 4; i++) begin
				if (ras_cnt_ff[i] != 4'h0) begin
					ras_cnt_ff[i] <= ras_cnt_ff[i] - 4'h1;
				end
				if (bank_pre_ff[i]) begin
					if (rp_cnt_ff[i] <= 4'h1) begin
						bank_pre_ff[i] <= 1'b0; // R13
					end
					rp_cnt_ff[i] <= rp_cnt_ff[i] - 4'h1;
				end
				// auto precharge waits for row active time
				if (ap_pend_ff[i] && ras_cnt_ff[i] <= 4'h1 && !(burst_bank_ff == 2'(i)
						&& (rd_active_ff || wr_active_ff))) begin
					ap_pend_ff[i] <= 1'b0; // R16
					bank_open_ff[i] <= 1'b0; // R10
					bank_pre_ff[i] <= 1'b1;
					rp_cnt_ff[i] <= 4'(dsc_pkg::TRP_CYC);
				end
			end
			if (bus.cke) begin
				case (cmd)
				dsc_pkg::DSC_CMD_ACT: begin
					if (!bank_open_ff[bus.ba] && !bank_pre_ff[bus.ba]) begin // R7
						bank_open_ff[bus.ba] <= 1'b1;
						row_ff[bus.ba] <= bus.addr[ROW_W-1:0];
						last_row_ff <= bus.addr[ROW_W-1:0];
						ras_cnt_ff[bus.ba] <= 4'(dsc_pkg::TRAS_CYC);
					end
				end
				dsc_pkg::DSC_CMD_RD, dsc_pkg::DSC_CMD_WR: begin
					if (bank_open_ff[bus.ba]) begin
						last_row_ff <= row_ff[bus.ba]; // R8
						if (bus.addr[dsc_pkg::AP_BIT]) begin
							ap_pend_ff[bus.ba] <= 1'b1; // R9
						end
					end
				end
				dsc_pkg::DSC_CMD_PRE: begin
					for (int i = 0; i < 4; i++) begin
						// idle or precharging bank: no effect
						if ((bus.addr[dsc_pkg::AP_BIT] || bus.ba == 2'(i))
								&& bank_open_ff[i] && !ap_pend_ff[i]) begin // R12 R14
							bank_open_ff[i] <= 1'b0;
							bank_pre_ff[i] <= 1'b1;
							rp_cnt_ff[i] <= 4'(dsc_pkg::TRP_CYC);
						end
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// burst engine; any bank may start while another auto precharges
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_active_ff <= 1'b0;
			wr_active_ff <= 1'b0;
			burst_cnt_ff <= 4'h0;
			burst_bank_ff <= 2'h0;
			burst_col_ff <= 13'h0;
			burst_ap_ff <= 1'b0;
		end else begin
			if (burst_done) begin
				rd_active_ff <= 1'b0;
				wr_active_ff <= 1'b0;
				burst_cnt_ff <= 4'h0;
			end else if (burst_cnt_ff != 4'h0) begin
				burst_cnt_ff <= burst_cnt_ff - 4'h1;
			end
			if (bus.cke && (cmd == dsc_pkg::DSC_CMD_RD || cmd == dsc_pkg::DSC_CMD_WR)
					&& bank_open_ff[bus.ba]) begin // R15
				rd_active_ff <= cmd == dsc_pkg::DSC_CMD_RD;
				wr_active_ff <= cmd == dsc_pkg::DSC_CMD_WR;
				burst_cnt_ff <= 4'(dsc_pkg::BURST_CYC);
				burst_bank_ff <= bus.ba; // R8
				burst_col_ff <= {bus.addr[12:11], 1'b0, bus.addr[9:0]};
				burst_ap_ff <= bus.addr[dsc_pkg::AP_BIT];
			end else if (bus.cke && cmd == dsc_pkg::DSC_CMD_BST && rd_active_ff
					&& !burst_ap_ff) begin
				rd_active_ff <= 1'b0; // R18
				burst_cnt_ff <= 4'h0;
			end
		end
	end

	// write data path: mask high blocks the lane
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_mask_ff <= 2'h0;
			wr_data_ff <= 16'h0;
			wr_strobe_ff <= 1'b0;
		end else begin
			wr_strobe_ff <= wr_active_ff && bus.wr_valid && (bus.dm != 2'h3); // R11
			wr_mask_ff <= ~bus.dm;
			wr_data_ff <= bus.dq_wr;
		end
	end

	// mode registers, refresh and self refresh
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg_ff <= 14'h0;
			emode_reg_ff <= 14'h0;
			self_ref_ff <= 1'b0;
			ref_row_ff <= '0;
			busy_cnt_ff <= 4'h0;
			err_ff <= 1'b0;
		end else begin
			if (busy_cnt_ff != 4'h0) begin
				busy_cnt_ff <= busy_cnt_ff - 4'h1;
				if (!bus.cke && !self_ref_ff) begin
					err_ff <= 1'b1; // R22
				end
			end
			if (self_ref_ff) begin
				// exit timing is the controller's concern
				if (bus.cke) begin
					self_ref_ff <= 1'b0;
				end
			end else if (bus.cke && cmd == dsc_pkg::DSC_CMD_LMR) begin
				if (!all_idle || busy_cnt_ff != 4'h0) begin
					err_ff <= 1'b1; // R6
				end else if (bus.ba == dsc_pkg::BA_MODE) begin
					mode_reg_ff <= bus.addr; // R5
				end else if (bus.ba == dsc_pkg::BA_EMODE) begin
					emode_reg_ff <= bus.addr;
				end
				busy_cnt_ff <= 4'(dsc_pkg::TMRD_CYC);
			end else if (ref_ok) begin
				ref_row_ff <= ref_row_ff + 1'b1; // R19
				busy_cnt_ff <= 4'(dsc_pkg::TRFC_CYC);
			end else if (!bus.cke && cmd == dsc_pkg::DSC_CMD_REF && all_idle) begin
				self_ref_ff <= 1'b1; // R4
				ref_row_ff <= ref_row_ff + 1'b1;
			end
		end
	end
endmodule

/* hdl/dsc_pkg.sv */
package dsc_pkg;
	localparam int CLK_PERIOD_NS = 100;
	// rounds a time up to whole clock periods
	function automatic int ceil_div(input int a, input int b);
		return (a + b - 1) / b;
	endfunction
	// timing figures in ns, converted to cycles at the clock rate
	localparam int TRCD_NS = 20;
	localparam int TRAS_NS = 45;
	localparam int TRP_NS = 20;
	localparam int TMRD_NS = 15;
	localparam int TRFC_NS = 120;
	localparam int TREFI_NS = 7813;
	localparam int MAX_POSTED = 8;
	localparam int TRCD_CYC = ceil_div(TRCD_NS, CLK_PERIOD_NS);
	localparam int TRAS_CYC = ceil_div(TRAS_NS, CLK_PERIOD_NS);
	localparam int TRP_CYC = ceil_div(TRP_NS, CLK_PERIOD_NS);
	localparam int TMRD_CYC = ceil_div(TMRD_NS, CLK_PERIOD_NS);
	localparam int TRFC_CYC = ceil_div(TRFC_NS, CLK_PERIOD_NS);
	// longest interval rounds down
	localparam int TREFI_CYC = TREFI_NS / CLK_PERIOD_NS;
	localparam int BURST_LEN = 4;
	localparam int BURST_CYC = BURST_LEN / 2;
	localparam int NUM_BANKS = 4;
	localparam int ROW_W = 14;
	localparam int COL_W = 13;
	localparam int AP_BIT = 10;
	localparam logic [1:0] BA_MODE = 2'h0;
	localparam logic [1:0] BA_EMODE = 2'h1;
	// command code is {ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		DSC_CMD_LMR = 3'h0,
		DSC_CMD_REF = 3'h1,
		DSC_CMD_PRE = 3'h2,
		DSC_CMD_ACT = 3'h3,
		DSC_CMD_WR = 3'h4,
		DSC_CMD_RD = 3'h5,
		DSC_CMD_BST = 3'h6,
		DSC_CMD_NOP = 3'h7
	} dsc_cmd_e;
	// controller op codes on its user port
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_ACT = 3'h1;
	localparam logic [2:0] OP_RD = 3'h2;
	localparam logic [2:0] OP_WR = 3'h3;
	localparam logic [2:0] OP_PRE = 3'h4;
	localparam logic [2:0] OP_LMR = 3'h5;
	localparam logic [2:0] OP_BST = 3'h6;
	localparam logic [2:0] OP_SREF = 3'h7;
	// controller register map
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_CFG = 4'h3;
	localparam logic [31:0] CFG_RST = 32'h0000_0001;
endpackage

/* hdl/dsc_if.sv */
`timescale 1ns/1ps
interface dsc_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic [13:0] addr;
	logic [1:0] dm;
	logic [15:0] dq_wr;
	logic wr_valid;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_wr, wr_valid);
	modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_wr, wr_valid);
endinterface

/* hdl/dsc_cmd_decode.sv */
`timescale 1ns/1ps
// turns sampled pins into a command; deselect and nop both give nop
module dsc_cmd_decode (
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	output dsc_pkg::dsc_cmd_e cmd
);
	always_comb begin
		if (cs_n) begin
			cmd = dsc_pkg::DSC_CMD_NOP; // R1
		end else begin
			cmd = dsc_pkg::dsc_cmd_e'({ras_n, cas_n, we_n}); // R2 R3
		end
	end
endmodule

/* hdl/dsc_ctrl.sv */
`timescale 1ns/1ps
// register-driven controller end; refresh scheduled on its own
module dsc_ctrl (
	input wire logic clock,
	input wire logic sys_rst,
	dsc_if.ctrl bus,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_ff,
	input wire logic [1:0] wr_dm,
	input wire logic [15:0] wr_data,
	input wire logic wr_data_valid
);
	logic [15:0] addr_ff;
	logic [31:0] cfg_ff;
	logic [15:0] ref_tmr_ff;
	logic [3:0] owed_ff;
	logic [3:0] wait_ff;
	logic [2:0] op_ff;
	logic ref_pend;
	logic ref_issue;
	logic ref_tick;

	assign ref_pend = owed_ff != 4'h0;
	assign ref_issue = cfg_ff[0] && ref_pend && wait_ff == 4'h0 && op_ff == dsc_pkg::OP_NONE;
	assign ref_tick = ref_tmr_ff == 16'(dsc_pkg::TREFI_CYC - 1);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			addr_ff <= 16'h0;
			cfg_ff <= dsc_pkg::CFG_RST;
		end else if (reg_wr && reg_addr == dsc_pkg::REG_ADDR) begin
			addr_ff <= reg_wdata[15:0];
		end else if (reg_wr && reg_addr == dsc_pkg::REG_CFG) begin
			cfg_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_ff <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
			dsc_pkg::REG_ADDR: reg_rdata_ff <= {16'h0, addr_ff};
			dsc_pkg::REG_STAT: reg_rdata_ff <= {24'h0, owed_ff, wait_ff};
			dsc_pkg::REG_CFG: reg_rdata_ff <= cfg_ff;
			default: reg_rdata_ff <= 32'h0;
			endcase
		end
	end

	// refresh owed count; cfg bit 0 enables automatic refresh
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ref_tmr_ff <= 16'h0;
			owed_ff <= 4'h0;
		end else begin
			ref_tmr_ff <= ref_tick ? 16'h0 : ref_tmr_ff + 16'h1; // R20
			if (ref_tick && !ref_issue && owed_ff <= 4'(dsc_pkg::MAX_POSTED)) begin
				owed_ff <= owed_ff + 4'h1; // R21
			end else if (ref_issue && !ref_tick) begin
				owed_ff <= owed_ff - 4'h1;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			op_ff <= dsc_pkg::OP_NONE;
		end else if (reg_wr && reg_addr == dsc_pkg::REG_CMD) begin
			op_ff <= reg_wdata[2:0];
		end else if (wait_ff == 4'h0 && !(cfg_ff[0] && ref_pend && op_ff == dsc_pkg::OP_NONE)) begin
			op_ff <= dsc_pkg::OP_NONE;
		end
	end

	// pins change after the edge so the memory samples them stable
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bus.cke <= 1'b0;
			bus.cs_n <= 1'b1;
			{bus.ras_n, bus.cas_n, bus.we_n} <= 3'h7;
			bus.ba <= 2'h0;
			bus.addr <= 14'h0;
			wait_ff <= 4'h0;
			bus.dm <= 2'h3;
			bus.dq_wr <= 16'h0;
			bus.wr_valid <= 1'b0;
		end else begin
			bus.cke <= op_ff != dsc_pkg::OP_SREF; // R4 R22 R23
			bus.cs_n <= 1'b1;
			{bus.ras_n, bus.cas_n, bus.we_n} <= 3'h7;
			bus.ba <= addr_ff[15:14];
			bus.addr <= addr_ff[13:0];
			bus.dm <= wr_data_valid ? wr_dm : 2'h3; // R11
			bus.dq_wr <= wr_data;
			bus.wr_valid <= wr_data_valid;
			if (wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1; // R6 R17
			end else if (cfg_ff[0] && ref_pend && op_ff == dsc_pkg::OP_NONE) begin
				bus.cs_n <= 1'b0; // R19
				{bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_REF;
				wait_ff <= 4'(dsc_pkg::TRFC_CYC);
			end else if (op_ff != dsc_pkg::OP_NONE) begin
				bus.cs_n <= 1'b0; // R3
				case (op_ff)
				dsc_pkg::OP_ACT: begin
					{bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_ACT;
					wait_ff <= 4'(dsc_pkg::TRCD_CYC);
				end
				dsc_pkg::OP_RD: {bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_RD;
				dsc_pkg::OP_WR: {bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_WR;
				dsc_pkg::OP_PRE: begin
					{bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_PRE;
					wait_ff <= 4'(dsc_pkg::TRP_CYC);
				end
				dsc_pkg::OP_LMR: begin
					{bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_LMR; // R5
					wait_ff <= 4'(dsc_pkg::TMRD_CYC);
				end
				dsc_pkg::OP_BST: {bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_BST; // R18
				dsc_pkg::OP_SREF: begin
					bus.cke <= 1'b0;
					{bus.ras_n, bus.cas_n, bus.we_n} <= dsc_pkg::DSC_CMD_REF;
				end
				default: bus.cs_n <= 1'b1;
				endcase
			end
		end
	end
endmodule

/* bench/dsc_chk.sv */
`timescale 1ns/1ps
module dsc_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [13:0] addr
);
	localparam int GAP_MAX = 9 * dsc_pkg::TREFI_CYC;
	wire [2:0] cmd = {ras_n, cas_n, we_n};
	wire sel = !cs_n;
	wire act = sel && cmd == dsc_pkg::DSC_CMD_ACT;
	wire rd = sel && cmd == dsc_pkg::DSC_CMD_RD;
	wire wr = sel && cmd == dsc_pkg::DSC_CMD_WR;
	wire pre = sel && cmd == dsc_pkg::DSC_CMD_PRE;
	wire refr = sel && cmd == dsc_pkg::DSC_CMD_REF;
	wire lmr = sel && cmd == dsc_pkg::DSC_CMD_LMR;
	wire bst = sel && cmd == dsc_pkg::DSC_CMD_BST;
	wire nop = cmd == dsc_pkg::DSC_CMD_NOP;
	logic [3:0] open_ff;
	logic plain_rd_ff;
	logic ref_seen_ff;
	int gap_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// closes at the command itself, so late auto precharge never trips it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			open_ff <= 4'h0;
		end else if (act) begin
			open_ff[ba] <= 1'b1;
		end else if (pre) begin
			open_ff <= addr[10] ? 4'h0 : open_ff & ~(4'h1 << ba);
		end else if ((rd || wr) && addr[10]) begin
			open_ff[ba] <= 1'b0;
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			plain_rd_ff <= 1'b0;
		end else if (rd || wr) begin
			plain_rd_ff <= rd && !addr[10];
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ref_seen_ff <= 1'b0;
			gap_ff <= 0;
		end else begin
			ref_seen_ff <= ref_seen_ff || refr;
			gap_ff <= refr ? 0 : gap_ff + 1;
		end
	end
	cke_cmd_a: assert property (
		sel && !nop && !refr |-> cke) else $error("command with clock enable low");
	ref_cke_a: assert property (
		refr && cke |=> cke[*2]) else $error("clock enable dropped in refresh");
	ref_quiet_a: assert property (
		refr && cke |=> !(sel && !nop)) else $error("command inside refresh time");
	lmr_idle_a: assert property (
		lmr |-> open_ff == 4'h0) else $error("mode load with open bank");
	ref_idle_a: assert property (
		refr |-> open_ff == 4'h0) else $error("refresh with open bank");
	lmr_bank_a: assert property (
		lmr |-> ba[1] == 1'b0) else $error("mode load to reserved bank code");
	act_closed_a: assert property (
		act |-> !open_ff[ba]) else $error("activate to open bank");
	rdwr_open_a: assert property (
		rd || wr |-> open_ff[ba]) else $error("access to closed bank");
	bst_plain_a: assert property (
		bst |-> plain_rd_ff) else $error("terminate after write or precharge read");
	ref_gap_a: assert property (
		ref_seen_ff |-> gap_ff <= GAP_MAX) else $error("refresh gap too long");
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata_ff;
	logic [1:0] wr_dm = 2'h3;
	logic [15:0] wr_data = 16'h0;
	logic wr_data_valid = 1'b0;
	logic [3:0] bank_open_ff, bank_pre_ff;
	logic [13:0] last_row_ff, mode_reg_ff, emode_reg_ff;
	logic [12:0] ref_row_ff, burst_col_ff;
	logic [1:0] burst_bank_ff, wr_mask_ff, got_mask;
	logic [15:0] wr_data_ff, got_data;
	logic self_ref_ff, rd_active_ff, wr_active_ff, wr_strobe_ff, err_ff;
	int failures = 0;
	int checks = 0;
	int refs = 0;
	wire [2:0] pin_cmd;
	dsc_if dsc_if_i();
	assign pin_cmd = {dsc_if_i.ras_n, dsc_if_i.cas_n, dsc_if_i.we_n};
	dsc_ctrl dsc_ctrl_i(.clock, .sys_rst, .bus(dsc_if_i.ctrl), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata_ff, .wr_dm, .wr_data, .wr_data_valid);
	dsc_mem dsc_mem_i(.clock, .sys_rst, .bus(dsc_if_i.mem), .bank_open_ff, .bank_pre_ff,
		.last_row_ff, .mode_reg_ff, .emode_reg_ff, .self_ref_ff, .ref_row_ff, .rd_active_ff,
		.wr_active_ff, .burst_bank_ff, .burst_col_ff, .wr_mask_ff, .wr_data_ff, .wr_strobe_ff,
		.err_ff);
	dsc_chk dsc_chk_i(.clock, .sys_rst, .cke(dsc_if_i.cke), .cs_n(dsc_if_i.cs_n),
		.ras_n(dsc_if_i.ras_n), .cas_n(dsc_if_i.cas_n), .we_n(dsc_if_i.we_n), .ba(dsc_if_i.ba),
		.addr(dsc_if_i.addr));
	always #50 clock = ~clock;
	// strobe is a pulse, so catch it mid-cycle
	always @(negedge clock) begin
		if (wr_strobe_ff === 1'b1) begin
			got_mask <= wr_mask_ff;
			got_data <= wr_data_ff;
		end
	end
	always @(posedge clock) begin
		if (!dsc_if_i.cs_n && pin_cmd == 3'h1 && dsc_if_i.cke) begin
			refs <= refs + 1;
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// three writes on consecutive edges, strobe held high throughout
	task automatic wr3(input logic [3:0] a0, input logic [31:0] d0, input logic [3:0] a1,
			input logic [31:0] d1, input logic [3:0] a2, input logic [31:0] d2);
		@(posedge clock);
		reg_addr <= a0;
		reg_wdata <= d0;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_addr <= a1;
		reg_wdata <= d1;
		@(posedge clock);
		reg_addr <= a2;
		reg_wdata <= d2;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk("reg", reg_rdata_ff, e);
	endtask
	// returns mid-cycle once the memory has taken the command
	task automatic op(input logic [2:0] o, input logic [1:0] b, input logic [13:0] a);
		int n;
		wr(dsc_pkg::REG_ADDR, {16'h0, b, a});
		wr(dsc_pkg::REG_CMD, {29'h0, o});
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while ((dsc_if_i.cs_n !== 1'b0 || pin_cmd === 3'h7) && n < 50);
		if (n >= 50) failures++;
		@(negedge clock);
	endtask
	task automatic summarize;
		if (failures == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		failures++;
		summarize;
	end
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rd(dsc_pkg::REG_CFG, dsc_pkg::CFG_RST);
		wr(dsc_pkg::REG_CFG, 32'h0);
		wr(4'hF, 32'hFFFF_FFFF);
		rd(dsc_pkg::REG_CFG, 32'h0);
		rd(dsc_pkg::REG_STAT, 32'h0);
		chk("open", bank_open_ff, 4'h0);
		op(dsc_pkg::OP_ACT, 2'h1, 14'h1234);
		chk("open", bank_open_ff, 4'h2);
		chk("row", last_row_ff, 14'h1234);
		op(dsc_pkg::OP_RD, 2'h1, 14'h0005);
		chk("bank", burst_bank_ff, 2'h1);
		chk("col", burst_col_ff, 13'h0005);
		repeat (10) @(negedge clock);
		chk("open", bank_open_ff, 4'h2);
		@(posedge clock);
		wr_dm <= 2'h2;
		wr_data <= 16'hA5C3;
		wr_data_valid <= 1'b1;
		op(dsc_pkg::OP_WR, 2'h1, 14'h0407);
		chk("wr", wr_active_ff, 1'b1);
		chk("col", burst_col_ff, 13'h0007);
		repeat (10) @(negedge clock);
		chk("mask", got_mask, 2'h1);
		chk("data", got_data, 16'hA5C3);
		chk("open", bank_open_ff, 4'h0);
		@(posedge clock);
		wr_data_valid <= 1'b0;
		wr_dm <= 2'h3;
		op(dsc_pkg::OP_ACT, 2'h1, 14'h0033);
		// read and terminate back to back so the stop lands mid-burst
		wr3(dsc_pkg::REG_ADDR, {16'h0, 2'h1, 14'h0003},
			dsc_pkg::REG_CMD, {29'h0, dsc_pkg::OP_RD},
			dsc_pkg::REG_CMD, {29'h0, dsc_pkg::OP_BST});
		repeat (2) @(negedge clock);
		chk("rd", rd_active_ff, 1'b1);
		@(negedge clock);
		chk("rd", rd_active_ff, 1'b0);
		repeat (10) @(negedge clock);
		chk("rd", rd_active_ff, 1'b0);
		chk("open", bank_open_ff, 4'h2);
		op(dsc_pkg::OP_ACT, 2'h2, 14'h0100);
		op(dsc_pkg::OP_ACT, 2'h3, 14'h0200);
		op(dsc_pkg::OP_PRE, 2'h2, 14'h0000);
		chk("pre", bank_pre_ff, 4'h4);
		repeat (4) @(negedge clock);
		chk("open", bank_open_ff, 4'hA);
		op(dsc_pkg::OP_PRE, 2'h0, 14'h0400);
		repeat (4) @(negedge clock);
		chk("open", bank_open_ff, 4'h0);
		op(dsc_pkg::OP_PRE, 2'h0, 14'h0000);
		chk("pre", bank_pre_ff, 4'h0);
		repeat (4) @(negedge clock);
		chk("open", bank_open_ff, 4'h0);
		op(dsc_pkg::OP_LMR, 2'h0, 14'h0123);
		chk("mode", mode_reg_ff, 14'h0123);
		op(dsc_pkg::OP_LMR, 2'h1, 14'h0042);
		chk("emode", emode_reg_ff, 14'h0042);
		chk("mode", mode_reg_ff, 14'h0123);
		op(dsc_pkg::OP_ACT, 2'h0, 14'h0011);
		op(dsc_pkg::OP_ACT, 2'h1, 14'h0022);
		wr(dsc_pkg::REG_ADDR, {16'h0, 2'h0, 14'h0401});
		// second read lands while bank 0 still waits to auto precharge
		wr3(dsc_pkg::REG_CMD, {29'h0, dsc_pkg::OP_RD},
			dsc_pkg::REG_ADDR, {16'h0, 2'h1, 14'h0002},
			dsc_pkg::REG_CMD, {29'h0, dsc_pkg::OP_RD});
		@(negedge clock);
		chk("row", last_row_ff, 14'h0011);
		repeat (2) @(negedge clock);
		chk("bank", burst_bank_ff, 2'h1);
		chk("open", bank_open_ff, 4'h3);
		repeat (10) @(negedge clock);
		chk("open", bank_open_ff, 4'h2);
		op(dsc_pkg::OP_PRE, 2'h0, 14'h0400);
		chk("err", err_ff, 1'b0);
		wr(dsc_pkg::REG_CFG, 32'h1);
		repeat (200) @(negedge clock);
		wr(dsc_pkg::REG_CFG, 32'h0);
		repeat (10) @(negedge clock);
		chk("refs", refs >= 2, 1'b1);
		chk("refrow", ref_row_ff, refs[12:0]);
		op(dsc_pkg::OP_SREF, 2'h0, 14'h0000);
		chk("sref", self_ref_ff, 1'b1);
		summarize;
	end
endmodule
